// >>> bench/cbr_atm_model.sv
// partner: atm layer side, makes the interface clock and the strobes
// assumes the bench sets rd_i and poll_i on the ref clock
`timescale 1ns/10ps
module cbr_atm_model (
   input wire logic rd_i,
   input wire logic [cbr_pkg::ADDR_W-1:0] poll_i,
   output logic if_clk_o,
   output logic enb_n_o,
   output logic [cbr_pkg::ADDR_W-1:0] addr_o
);
   initial begin
      if_clk_o = 1'b0;
      enb_n_o = 1'b1;
      addr_o = 5'h00;
      #37;
      forever #80 if_clk_o = ~if_clk_o;
   end
   // strobes move on the falling edge, half a period clear of sampling
   always @(negedge if_clk_o) begin
      enb_n_o <= !rd_i;
      addr_o <= poll_i;
   end
endmodule // cbr_atm_model

// >>> bench/cbr_rx_port_asserts.sv
// checker: output relations of the cell bus receive port
// assumes a bind onto cbr_rx_port, one ref clock domain
`timescale 1ns/10ps
module cbr_rx_port_asserts (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic rx_read_enable_n_i,
   input wire logic [cbr_pkg::ADDR_W-1:0] rx_port_select_addr_i,
   input wire logic [cbr_pkg::ADDR_W-1:0] port_addr_i,
   input wire logic bus16_mode_i,
   input wire logic octet_flow_i,
   input wire logic [cbr_pkg::DATA_W-1:0] rx_cell_data_bus_o,
   input wire logic rx_cell_data_bus_oe_o,
   input wire logic rx_bus_parity_o,
   input wire logic rx_bus_parity_oe_o,
   input wire logic rx_cell_start_flag_o,
   input wire logic rx_cell_start_flag_oe_o,
   input wire logic rx_cell_available_oe_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   logic [5:0] en_age;
   logic [5:0] ad_age;
   // ages saturate so a long idle never wraps into a false match
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !rx_read_enable_n_i) en_age <= 6'h00;
      else en_age <= en_age + 6'(en_age != 6'h3f);
   end
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || rx_port_select_addr_i == port_addr_i) ad_age <= 6'h00;
      else ad_age <= ad_age + 6'(ad_age != 6'h3f);
   end
   sequence soc_hold_s;
      rx_cell_start_flag_o [*8] ##[1:16] !rx_cell_start_flag_o;
   endsequence
   parity_eight_a: assert property (rx_bus_parity_oe_o && !bus16_mode_i |->
      rx_bus_parity_o == ~^rx_cell_data_bus_o[7:0]) else $error("odd parity 8 wrong");
   parity_wide_a: assert property (rx_bus_parity_oe_o && bus16_mode_i |->
      rx_bus_parity_o == ~^rx_cell_data_bus_o) else $error("odd parity 16 wrong");
   parity_drive_a: assert property (rx_bus_parity_oe_o |-> en_age < 6'h18)
      else $error("parity driven without enable");
   bus_drive_a: assert property (rx_cell_data_bus_oe_o || rx_cell_start_flag_oe_o |->
      en_age < 6'h18) else $error("bus driven without enable");
   soc_pulse_a: assert property ($rose(rx_cell_start_flag_o) |-> soc_hold_s)
      else $error("start flag length wrong");
   soc_bus_a: assert property (rx_cell_start_flag_o |-> rx_cell_data_bus_oe_o)
      else $error("start flag without data");
   poll_drive_a: assert property (!octet_flow_i && rx_cell_available_oe_o |->
      ad_age < 6'h18) else $error("available driven unpolled");
   reset_idle_a: assert property ($fell(reset_i) |-> !rx_cell_available_oe_o &&
      !rx_cell_start_flag_oe_o && !rx_bus_parity_oe_o) else $error("outputs driven at reset");
   data_stand_a: assert property ($changed(rx_cell_data_bus_o) |=>
      $stable(rx_cell_data_bus_o) [*8]) else $error("data did not stand");
endmodule // cbr_rx_port_asserts
bind cbr_rx_port cbr_rx_port_asserts u_chk (.*);

// >>> bench/cbr_rx_port_tb.sv
// testbench: cell bus receive port against a queue model, three modes
// assumes the partner model makes the interface clock and strobes
`timescale 1ns/10ps
module cbr_rx_port_tb;
   logic ref_clk_i, reset_i, b16, oct, vld, fst, rd, prev_rd, r, ick, enb_n;
   logic rdy, doe, par, poe, soc, soe, av, aoe;
   logic [15:0] data, dbus;
   logic [4:0] paddr, poll, sel;
   logic [16:0] q[$];
   logic [16:0] w;
   int err_count, checks, seed;
   cbr_atm_model u_atm (.rd_i(rd), .poll_i(poll), .if_clk_o(ick), .enb_n_o(enb_n),
      .addr_o(sel));
   cbr_rx_port dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
      .rx_if_clk_i(ick), .rx_read_enable_n_i(enb_n), .rx_port_select_addr_i(sel),
      .port_addr_i(paddr), .bus16_mode_i(b16), .octet_flow_i(oct), .cell_in_valid_i(vld),
      .cell_in_ready_o(rdy), .cell_in_data_i(data), .cell_in_first_i(fst),
      .rx_cell_data_bus_o(dbus), .rx_cell_data_bus_oe_o(doe), .rx_bus_parity_o(par),
      .rx_bus_parity_oe_o(poe), .rx_cell_start_flag_o(soc), .rx_cell_start_flag_oe_o(soe),
      .rx_cell_available_o(av), .rx_cell_available_oe_o(aoe));
   task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   endtask
   task final_report;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // sample at the pin edge, drive on the next ref edge
   task automatic wait_if(input int n);
      repeat (n) @(posedge ick);
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ick) begin
      if (prev_rd && q.size() > 0) begin
         w = q.pop_front();
         cmp("data", b16 ? w[15:0] : {8'h00, w[7:0]}, b16 ? dbus : {8'h00, dbus[7:0]});
         cmp("parity", 16'(b16 ? ~^w[15:0] : ~^w[7:0]), 16'(par));
         cmp("start", 16'(w[16]), 16'(soc));
         cmp("drive", 16'h0007, 16'({doe, poe, soe}));
      end
      prev_rd = !enb_n;
   end
   task automatic run(input int m);
      reset_i <= 1'b1;
      b16 <= (m == 1);
      oct <= (m == 2);
      paddr <= 5'($random(seed));
      repeat (16) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      cmp("idle drive", 16'h0000, 16'({aoe, soe, poe}));
      for (int i = 0; i < 17; i++) begin
         vld <= 1'b1;
         fst <= (i == 0);
         data <= 16'($random(seed));
         @(negedge ref_clk_i) r = rdy;
         if (i == 16) cmp("ready full", 16'h0000, 16'(r));
         else if (r) q.push_back({fst, data});
         @(posedge ref_clk_i);
      end
      vld <= 1'b0;
      poll <= paddr;
      wait_if(3);
      if (m < 2) cmp("avail full", 16'h0003, 16'({aoe, av}));
      else cmp("avail octet", 16'h0003, 16'({aoe, av}));
      @(posedge ref_clk_i) poll <= ~paddr;
      wait_if(3);
      if (m < 2) cmp("avail unpolled", 16'h0000, 16'(aoe));
      @(posedge ref_clk_i) rd <= 1'b1;
      poll <= paddr;
      wait_if(18);
      @(posedge ref_clk_i) rd <= 1'b0;
      wait_if(3);
      cmp("released", 16'h0000, 16'({doe, poe, soe}));
      cmp("avail empty", 16'h0002, 16'({aoe, av}));
      cmp("left", 16'h0000, 16'(q.size()));
      @(posedge ref_clk_i);
   endtask
   initial begin
      seed = 79;
      reset_i = 1'b1;
      {b16, oct, vld, fst, rd, prev_rd} = 6'h00;
      data = 16'h0000;
      paddr = 5'h00;
      poll = 5'h00;
      for (int m = 0; m < 3; m++) run(m);
      final_report();
   end
endmodule // cbr_rx_port_tb

// >>> include/cbr_pkg.sv
// cbr_pkg: constants shared by the cell bus receive port files
// assumes a 100 MHz ref_clk_i and a receive interface clock sampled as a plain input
package cbr_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 5;
   localparam int CELL_BYTES = 53;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] CNT_FIRST = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
   localparam logic [CNT_W-1:0] CELL_LAST_8 = 6'h34;
   localparam logic [CNT_W-1:0] CELL_LAST_16 = 6'h1a;
   localparam logic [ADDR_W-1:0] PORT_ADDR_DEF = 5'h00;
   localparam logic [4:0] FIFO_CELL_MIN_8 = 5'h10;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   typedef enum logic [1:0] {
      CBR_IDLE = 2'b01,
      CBR_SEND = 2'b10
   } cbr_state_type;
endpackage

// >>> src/cbr_fifo.sv
// cbr_fifo: synchronous valid/ready fifo between the cell source and the bus port
// assumes both sides on ref_clk_i; clk_en_i freezes all state
`timescale 1ns/10ps
module cbr_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic push;
   logic pop;

   assign in_ready_o = (count != (PW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign push = in_valid_i && in_ready_o && clk_en_i;
   assign pop = out_valid_o && out_ready_i && clk_en_i;
   assign out_data_o = mem[rd_ptr];
   assign level_o = count;

   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + PW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + PW'(1);
         end
         if (push && !pop) begin
            count <= count + (PW+1)'(1);
         end else if (pop && !push) begin
            count <= count - (PW+1)'(1);
         end
      end
   end
endmodule // cbr_fifo

// >>> src/cbr_rx_port.sv
// cbr_rx_port: receive side of a shared multi-PHY cell bus port
// assumes the partner drives the interface clock, enable and address; the pad
// ring resolves each output from its enable; cells enter as words with a start mark
`timescale 1ns/10ps
// How it works
// RULE_01: in 8-bit mode the parity pin carries odd parity over data bits 7:0.
// RULE_02: in 16-bit mode the parity pin carries odd parity over data bits 15:0.
// RULE_03: the parity pin is driven only in cycles after one with read enable low.
// RULE_04: the start flag is high exactly while the bus carries a cell's first word.
// RULE_05: data and start flag are driven only in cycles after one with read enable low.
// RULE_06: in octet flow control the available pin is an active-low empty flag.
// RULE_07: in cell flow control the available pin is driven only the cycle after our address.
// RULE_08: when polled, available is high if a whole cell is buffered, low otherwise; the code raises it only when all 16 buffer words are full.
// RULE_09: after reset the port is in level 2 mode with available, start and parity undriven.
// RULE_10: bit 15 is the high octet msb and bit 7 the low octet msb.
// RULE_11: data, parity and start flag change together on one interface clock edge.
module cbr_rx_port (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic rx_if_clk_i,
   input wire logic rx_read_enable_n_i,
   input wire logic [cbr_pkg::ADDR_W-1:0] rx_port_select_addr_i,
   input wire logic [cbr_pkg::ADDR_W-1:0] port_addr_i,
   input wire logic bus16_mode_i,
   input wire logic octet_flow_i,
   input wire logic cell_in_valid_i,
   output logic cell_in_ready_o,
   input wire logic [cbr_pkg::DATA_W-1:0] cell_in_data_i,
   input wire logic cell_in_first_i,
   output logic [cbr_pkg::DATA_W-1:0] rx_cell_data_bus_o,
   output logic rx_cell_data_bus_oe_o,
   output logic rx_bus_parity_o,
   output logic rx_bus_parity_oe_o,
   output logic rx_cell_start_flag_o,
   output logic rx_cell_start_flag_oe_o,
   output logic rx_cell_available_o,
   output logic rx_cell_available_oe_o
);
   localparam int FW = cbr_pkg::DATA_W + 1;

   // two-stage synchronisers for everything arriving from the partner
   logic clk_s1, clk_s2, clk_s3;
   logic enb_s1, enb_s2;
   logic [cbr_pkg::ADDR_W-1:0] addr_s1, addr_s2;
   logic if_edge;

   logic f_valid;
   logic f_ready;
   logic [FW-1:0] f_data;
   logic [$clog2(cbr_pkg::FIFO_DEPTH):0] f_level;
   logic [cbr_pkg::CNT_W-1:0] word_cnt;
   logic [cbr_pkg::CNT_W-1:0] last_word;
   logic cell_ready;
   logic take;
   cbr_pkg::cbr_state_type state;
   cbr_pkg::cbr_state_type next_state;

   function automatic logic odd_parity(input logic [cbr_pkg::DATA_W-1:0] d,
                                       input logic wide);
      odd_parity = wide ? ~(^d) : ~(^d[7:0]);  // RULE_01 RULE_02
   endfunction

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         clk_s1 <= 1'b0;
         clk_s2 <= 1'b0;
         clk_s3 <= 1'b0;
         enb_s1 <= 1'b1;
         enb_s2 <= 1'b1;
         addr_s1 <= '0;
         addr_s2 <= '0;
      end else if (clk_en_i) begin
         clk_s1 <= rx_if_clk_i;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
         enb_s1 <= rx_read_enable_n_i;
         enb_s2 <= enb_s1;
         addr_s1 <= rx_port_select_addr_i;
         addr_s2 <= addr_s1;
      end
   end

   // rising edge of the interface clock; every bus action happens on it
   assign if_edge = clk_s2 && !clk_s3 && clk_en_i;

   cbr_fifo #(
      .WIDTH(FW),
      .DEPTH(cbr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .in_valid_i(cell_in_valid_i),
      .in_ready_o(cell_in_ready_o),
      .in_data_i({cell_in_first_i, cell_in_data_i}),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready),
      .out_data_o(f_data),
      .level_o(f_level)
   );

   assign last_word = bus16_mode_i ? cbr_pkg::CELL_LAST_16 : cbr_pkg::CELL_LAST_8;
   // a 16-word buffer cannot hold a whole 8-bit cell; a full buffer stands in for it
   assign cell_ready = bus16_mode_i ?
      (f_level >= 5'(cbr_pkg::CELL_LAST_16 + cbr_pkg::CNT_ONE) ||
       f_level == cbr_pkg::FIFO_CELL_MIN_8) :
      (f_level == cbr_pkg::FIFO_CELL_MIN_8);

   // a word leaves the buffer on an interface edge while the partner reads us
   assign take = if_edge && !enb_s2 && f_valid &&
                 (octet_flow_i || state == cbr_pkg::CBR_SEND || f_data[FW-1]);
   assign f_ready = take;

   always_comb begin
      next_state = state;
      case (state)
         cbr_pkg::CBR_IDLE: begin
            if (take && !octet_flow_i) begin
               next_state = cbr_pkg::CBR_SEND;
            end
         end
         cbr_pkg::CBR_SEND: begin
            if (take && word_cnt == last_word) begin
               next_state = cbr_pkg::CBR_IDLE;
            end
         end
         default: begin
            next_state = cbr_pkg::CBR_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state <= cbr_pkg::CBR_IDLE;
         word_cnt <= cbr_pkg::CNT_FIRST;
      end else if (clk_en_i) begin
         state <= next_state;
         if (take) begin
            word_cnt <= f_data[FW-1] ? cbr_pkg::CNT_ONE : word_cnt + cbr_pkg::CNT_ONE;
         end
      end
   end

   // data, parity and start flag launch together from one edge
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rx_cell_data_bus_o <= cbr_pkg::DATA_ZERO;
         rx_bus_parity_o <= 1'b0;
         rx_cell_start_flag_o <= 1'b0;
      end else if (take) begin
         rx_cell_data_bus_o <= f_data[cbr_pkg::DATA_W-1:0];  // RULE_10 RULE_11
         rx_bus_parity_o <= odd_parity(f_data[cbr_pkg::DATA_W-1:0], bus16_mode_i);  // RULE_11
         rx_cell_start_flag_o <= f_data[FW-1];  // RULE_04 RULE_11
      end else if (if_edge) begin
         rx_cell_start_flag_o <= 1'b0;  // RULE_04
      end
   end

   // reset clears every enable, leaving the shared lines released
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rx_cell_data_bus_oe_o <= 1'b0;  // RULE_09
         rx_bus_parity_oe_o <= 1'b0;  // RULE_09
         rx_cell_start_flag_oe_o <= 1'b0;  // RULE_09
         rx_cell_available_oe_o <= 1'b0;  // RULE_09
         rx_cell_available_o <= 1'b0;
      end else if (if_edge) begin
         rx_cell_data_bus_oe_o <= !enb_s2;  // RULE_05
         rx_bus_parity_oe_o <= !enb_s2;  // RULE_03
         rx_cell_start_flag_oe_o <= !enb_s2;  // RULE_05
         if (octet_flow_i) begin
            rx_cell_available_oe_o <= 1'b1;
            // low means empty once this read has taken the last word
            rx_cell_available_o <= f_valid && !(take && f_level == 5'h01);  // RULE_06
         end else begin
            rx_cell_available_oe_o <= (addr_s2 == port_addr_i);  // RULE_07
            rx_cell_available_o <= cell_ready;  // RULE_08
         end
      end
   end
endmodule // cbr_rx_port
